// *** shared/asu_defines.vh ***
/*
  constants for the async serial unit: baud chain, frame, line codes.
  assumes inclusion by bare name from design files.
*/
`ifndef ASU_DEFINES_VH
`define ASU_DEFINES_VH
`define ASU_PRE_DIV1      3'h0
`define ASU_PRE_DIV3      3'h1
`define ASU_PRE_DIV4      3'h2
`define ASU_PRE_DIV13     3'h3
`define ASU_PRE_DIV39     3'h4
`define ASU_PRE_CNT1      6'h00
`define ASU_PRE_CNT3      6'h02
`define ASU_PRE_CNT4      6'h03
`define ASU_PRE_CNT13     6'h0C
`define ASU_PRE_CNT39     6'h26
`define ASU_RATE_MAX      8'h7F
`define ASU_OVERSAMPLE    4'hF
`define ASU_SAMPLE_MID    4'h7
`define ASU_SAMPLE_A      4'h7
`define ASU_SAMPLE_B      4'h8
`define ASU_SAMPLE_C      4'h9
`define ASU_DATA_BITS     4'h8
`define ASU_FRAME_BITS    4'hA
`define ASU_IDLE_SAMPLES  8'h9F
`define ASU_LINE_IDLE     1'b1
`define ASU_LINE_START    1'b0
`endif

// *** logic/asu_baud_gen.v ***
/*
  baud timing chain: prescaler then binary divider giving the 16x sample
  enable, then divide by 16 for the bit enable.
  assumes the asu defines header and a single clock domain.
*/
`timescale 1ns/1ps
`include "asu_defines.vh"
module asu_baud_gen
(
  // clock and reset
  input  wire       mclk,
  input  wire       rst_n,
  // rate selects
  input  wire [2:0] baud_prescale_sel,
  input  wire [2:0] baud_rate_sel,
  // enables
  output reg        sample_clock,
  output reg        bit_clock
);
  reg  [5:0] pre_cnt_reg;
  reg  [6:0] rate_cnt_reg;
  reg  [3:0] bit_cnt_reg;
  reg  [5:0] pre_top;
  reg  [6:0] rate_top;
  reg  [7:0] rate_span;
  wire       pre_tick;
  wire       rate_tick;

  // unused codes fall back to divide by 1
  always @*
  begin
    case (baud_prescale_sel)
      `ASU_PRE_DIV1:  pre_top = `ASU_PRE_CNT1;
      `ASU_PRE_DIV3:  pre_top = `ASU_PRE_CNT3;
      `ASU_PRE_DIV4:  pre_top = `ASU_PRE_CNT4;
      `ASU_PRE_DIV13: pre_top = `ASU_PRE_CNT13;
      `ASU_PRE_DIV39: pre_top = `ASU_PRE_CNT39;
      default:        pre_top = `ASU_PRE_CNT1;
    endcase
    rate_span = (`ASU_RATE_MAX >> (3'h7 - baud_rate_sel));
    rate_top  = rate_span[6:0];
  end

  assign pre_tick  = (pre_cnt_reg >= pre_top);
  assign rate_tick = pre_tick && (rate_cnt_reg >= rate_top);

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_cnt_reg  <= 6'h00;
      rate_cnt_reg <= 7'h00;
      bit_cnt_reg  <= 4'h0;
      sample_clock <= 1'b0;
      bit_clock    <= 1'b0;
    end
    else
    begin
      pre_cnt_reg  <= pre_tick ? 6'h00 : pre_cnt_reg + 6'h01;
      if (pre_tick)
        rate_cnt_reg <= rate_tick ? 7'h00 : rate_cnt_reg + 7'h01;
      sample_clock <= rate_tick;
      bit_clock    <= rate_tick && (bit_cnt_reg == `ASU_OVERSAMPLE);
      if (rate_tick)
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end
endmodule // asu_baud_gen

// *** logic/asu_rx_sampler.v ***
/*
  receive line synchroniser and three-sample majority voter.
  assumes rxd is an asynchronous pin and sample_clock a one-cycle enable.
*/
`timescale 1ns/1ps
`include "asu_defines.vh"
module asu_rx_sampler
(
  // clock and reset
  input  wire       mclk,
  input  wire       rst_n,
  // line
  input  wire       rxd,
  input  wire       sample_clock,
  input  wire [3:0] phase,
  // results
  output wire       line_level,
  output reg        vote,
  output reg        vote_noisy
);
  reg       sync1_reg;
  reg       sync2_reg;
  reg [1:0] samp_reg;

  assign line_level = sync2_reg;

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg  <= `ASU_LINE_IDLE;
      sync2_reg  <= `ASU_LINE_IDLE;
      samp_reg   <= 2'h3;
      vote       <= `ASU_LINE_IDLE;
      vote_noisy <= 1'b0;
    end
    else
    begin
      sync1_reg <= rxd;
      sync2_reg <= sync1_reg;
      if (sample_clock)
      begin
        if (phase == `ASU_SAMPLE_A) samp_reg[0] <= sync2_reg;
        if (phase == `ASU_SAMPLE_B) samp_reg[1] <= sync2_reg;
        if (phase == `ASU_SAMPLE_C)
        begin
          vote       <= (samp_reg[0] & samp_reg[1]) | (samp_reg[0] & sync2_reg) | (samp_reg[1] & sync2_reg);
          vote_noisy <= !((samp_reg[0] == samp_reg[1]) && (samp_reg[1] == sync2_reg));
        end
      end
    end
  end
endmodule // asu_rx_sampler

// *** logic/asu_core.v ***
/*
  async serial unit core: transmitter with empty/done flags and graceful
  shutdown, receiver with full, overrun, noise, framing and idle flags.
  assumes software strobes: status_rd marks a status read, data_wr a data
  write with tx_data, data_rd a data read. control bits are plain ports.
*/
`timescale 1ns/1ps
`include "asu_defines.vh"
module asu_core
(
  // clock and reset
  input  wire       mclk,
  input  wire       rst_n,
  // baud configuration
  input  wire [2:0] baud_prescale_sel,
  input  wire [2:0] baud_rate_sel,
  // control
  input  wire       tx_on,
  input  wire       rx_on,
  input  wire       rx_sleep_ctl,
  input  wire       tx_empty_irq_en,
  input  wire       tx_done_irq_en,
  input  wire       rx_irq_en,
  input  wire       idle_irq_en,
  // software access strobes
  input  wire       status_rd,
  input  wire       data_wr,
  input  wire       data_rd,
  input  wire [7:0] tx_data,
  // status and data
  output reg        tx_buf_empty_flag,
  output reg        tx_done_flag,
  output reg        rx_buf_full_flag,
  output reg        rx_overrun_flag,
  output reg        noise_flag,
  output reg        frame_error_flag,
  output reg        rx_idle_flag,
  output reg  [7:0] rx_hold_reg,
  output wire       irq_req,
  // serial pins
  input  wire       rxd,
  output reg        txd,
  output reg        txd_oe
);
  localparam TX_OFF   = 2'h0;
  localparam TX_IDLE  = 2'h1;
  localparam TX_SHIFT = 2'h2;

  wire       sample_clock;
  wire       bit_clock;
  wire       line_level;
  wire       vote;
  wire       vote_noisy;

  reg  [1:0] tx_state_reg;
  reg  [7:0] tx_hold_reg;
  reg  [9:0] tx_shift_reg;
  reg  [3:0] tx_cnt_reg;
  reg        tx_on_d_reg;
  reg        tx_stop_reg;
  reg        tx_seen_empty_reg;
  reg        tx_seen_done_reg;

  reg        rx_busy_reg;
  reg  [3:0] rx_phase_reg;
  reg  [3:0] rx_cnt_reg;
  reg  [7:0] rx_shift_reg;
  reg        rx_noise_acc_reg;
  reg  [7:0] idle_cnt_reg;
  reg        line_busy_reg;
  reg  [4:0] rx_seen_reg;

  wire       rx_bit_pt;
  wire       tx_start;
  wire       rx_done;
  wire       rx_store;
  wire       rx_over;
  wire       idle_now;
  wire       rx_clear;

  asu_baud_gen u_baud
  (
    .mclk              (mclk),
    .rst_n             (rst_n),
    .baud_prescale_sel (baud_prescale_sel),
    .baud_rate_sel     (baud_rate_sel),
    .sample_clock      (sample_clock),
    .bit_clock         (bit_clock)
  );

  asu_rx_sampler u_samp
  (
    .mclk         (mclk),
    .rst_n        (rst_n),
    .rxd          (rxd),
    .sample_clock (sample_clock),
    .phase        (rx_phase_reg),
    .line_level   (line_level),
    .vote         (vote),
    .vote_noisy   (vote_noisy)
  );

  // only three receive flags and two transmit flags reach the request
  assign irq_req = (tx_buf_empty_flag && tx_empty_irq_en)
                 | (tx_done_flag && tx_done_irq_en)
                 | ((rx_buf_full_flag | rx_overrun_flag) && rx_irq_en && !rx_sleep_ctl)
                 | (rx_idle_flag && idle_irq_en);

  // queued character starts on a bit clock while enabled
  assign tx_start = bit_clock && (tx_state_reg == TX_IDLE) && tx_on && !tx_buf_empty_flag;

  // transmitter state machine
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_state_reg <= TX_OFF;
      tx_shift_reg <= 10'h3FF;
      tx_cnt_reg   <= 4'h0;
      tx_hold_reg  <= 8'h00;
      tx_on_d_reg  <= 1'b0;
      tx_stop_reg  <= 1'b0;
      txd          <= `ASU_LINE_IDLE;
      txd_oe       <= 1'b0;
    end
    else
    begin
      tx_on_d_reg <= tx_on;
      if (data_wr)
        tx_hold_reg <= tx_data;
      if (!tx_on && tx_state_reg == TX_SHIFT)
        tx_stop_reg <= 1'b1;
      case (tx_state_reg)
        TX_OFF:
        begin
          if (tx_on && !tx_on_d_reg)
          begin
            tx_state_reg <= TX_IDLE;
            txd_oe       <= 1'b1;
            txd          <= `ASU_LINE_IDLE;
          end
        end
        TX_IDLE:
        begin
          if (!tx_on && bit_clock)
          begin
            tx_state_reg <= TX_OFF;
            txd_oe       <= 1'b0;
          end
          else if (tx_start)
          begin
            tx_shift_reg <= {`ASU_LINE_IDLE, tx_hold_reg, `ASU_LINE_START};
            tx_cnt_reg   <= 4'h0;
            tx_state_reg <= TX_SHIFT;
          end
        end
        TX_SHIFT:
        begin
          if (bit_clock && tx_cnt_reg == `ASU_FRAME_BITS)
          begin
            // stop bit has stood a full bit time before the pin is let go
            tx_stop_reg <= 1'b0;
            if (tx_stop_reg || !tx_on)
            begin
              tx_state_reg <= TX_OFF;
              txd_oe       <= 1'b0;
            end
            else
              tx_state_reg <= TX_IDLE;
          end
          else if (bit_clock)
          begin
            txd          <= tx_shift_reg[0];
            tx_shift_reg <= {`ASU_LINE_IDLE, tx_shift_reg[9:1]};
            tx_cnt_reg   <= tx_cnt_reg + 4'h1;
          end
        end
        default:
          tx_state_reg <= TX_OFF;
      endcase
    end
  end

  // transmit flags; set wins over the clearing write
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_buf_empty_flag <= 1'b0;
      tx_done_flag      <= 1'b0;
      tx_seen_empty_reg <= 1'b0;
      tx_seen_done_reg  <= 1'b0;
    end
    else
    begin
      if (status_rd)
      begin
        tx_seen_empty_reg <= tx_buf_empty_flag;
        tx_seen_done_reg  <= tx_done_flag;
      end
      else if (data_wr)
      begin
        tx_seen_empty_reg <= 1'b0;
        tx_seen_done_reg  <= 1'b0;
      end
      if (data_wr && tx_seen_empty_reg)
        tx_buf_empty_flag <= 1'b0;
      if (data_wr && tx_seen_done_reg)
        tx_done_flag <= 1'b0;
      if (tx_on && !tx_on_d_reg)
      begin
        tx_buf_empty_flag <= 1'b1;
        tx_done_flag      <= 1'b1;
      end
      if (tx_start)
        tx_buf_empty_flag <= 1'b1;
      if (tx_state_reg == TX_SHIFT && bit_clock && tx_cnt_reg == `ASU_FRAME_BITS)
      begin
        if (tx_buf_empty_flag || tx_stop_reg || !tx_on)
          tx_done_flag <= 1'b1;
        if (tx_stop_reg || !tx_on)
          tx_buf_empty_flag <= 1'b1;
      end
    end
  end

  // receiver: phase counts samples within a bit, centre vote sample at phase 8
  assign rx_bit_pt = sample_clock && rx_busy_reg && (rx_phase_reg == `ASU_SAMPLE_C + 4'h1);
  assign rx_done   = rx_bit_pt && (rx_cnt_reg == `ASU_FRAME_BITS - 4'h1);
  assign rx_store  = rx_done && !rx_buf_full_flag;
  assign rx_over   = rx_done && rx_buf_full_flag;

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_busy_reg      <= 1'b0;
      rx_phase_reg     <= 4'h0;
      rx_cnt_reg       <= 4'h0;
      rx_shift_reg     <= 8'h00;
      rx_noise_acc_reg <= 1'b0;
      rx_hold_reg      <= 8'h00;
    end
    else if (sample_clock)
    begin
      rx_phase_reg <= rx_phase_reg + 4'h1;
      if (!rx_busy_reg)
      begin
        rx_phase_reg <= 4'h0;
        if (rx_on && line_level == `ASU_LINE_START)
        begin
          rx_busy_reg      <= 1'b1;
          rx_cnt_reg       <= 4'h0;
          rx_noise_acc_reg <= 1'b0;
        end
      end
      else if (rx_bit_pt)
      begin
        rx_noise_acc_reg <= rx_noise_acc_reg | vote_noisy;
        rx_cnt_reg       <= rx_cnt_reg + 4'h1;
        if (rx_cnt_reg == 4'h0 && vote != `ASU_LINE_START)
          rx_busy_reg <= 1'b0;
        else if (rx_cnt_reg <= `ASU_DATA_BITS && rx_cnt_reg != 4'h0)
          rx_shift_reg <= {vote, rx_shift_reg[7:1]};
        if (rx_done)
        begin
          rx_busy_reg <= 1'b0;
          if (!rx_buf_full_flag)
            rx_hold_reg <= rx_shift_reg;
        end
      end
    end
  end

  // idle detection: ones for a full character of samples
  assign idle_now = (idle_cnt_reg == `ASU_IDLE_SAMPLES);
  assign rx_clear = data_rd;

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idle_cnt_reg  <= 8'h00;
      line_busy_reg <= 1'b0;
    end
    else if (sample_clock)
    begin
      if (line_level != `ASU_LINE_IDLE)
      begin
        idle_cnt_reg  <= 8'h00;
        line_busy_reg <= 1'b1;
      end
      else if (!idle_now)
        idle_cnt_reg <= idle_cnt_reg + 8'h01;
      else
        line_busy_reg <= 1'b0;
    end
  end

  // receive flags; hardware set wins over software clear
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_buf_full_flag <= 1'b0;
      rx_overrun_flag  <= 1'b0;
      noise_flag       <= 1'b0;
      frame_error_flag <= 1'b0;
      rx_idle_flag     <= 1'b0;
      rx_seen_reg      <= 5'h00;
    end
    else
    begin
      if (status_rd)
        rx_seen_reg <= {rx_idle_flag, frame_error_flag, noise_flag, rx_overrun_flag, rx_buf_full_flag};
      else if (data_rd)
        rx_seen_reg <= 5'h00;
      if (rx_clear)
      begin
        if (rx_seen_reg[0]) rx_buf_full_flag <= 1'b0;
        if (rx_seen_reg[1]) rx_overrun_flag  <= 1'b0;
        if (rx_seen_reg[2]) noise_flag       <= 1'b0;
        if (rx_seen_reg[3]) frame_error_flag <= 1'b0;
        if (rx_seen_reg[4]) rx_idle_flag     <= 1'b0;
      end
      if (rx_store)
      begin
        rx_buf_full_flag <= 1'b1;
        noise_flag       <= rx_noise_acc_reg | vote_noisy;
        frame_error_flag <= (vote != `ASU_LINE_IDLE);
      end
      if (rx_over)
        rx_overrun_flag <= 1'b1;
      if (sample_clock && line_busy_reg && idle_now && line_level == `ASU_LINE_IDLE && !rx_sleep_ctl)
        rx_idle_flag <= 1'b1;
    end
  end
endmodule // asu_core

// *** testbench/asu_core_assertions.sv ***
/*
  port checker for asu_core: irq gating, flag set and clear timing, idle rules.
  assumes one mclk domain and is bound to every asu_core instance.
*/
`timescale 1ns/1ps
module asu_core_chk
(
  // clock and reset
  input wire       mclk,
  input wire       rst_n,
  // control and strobes
  input wire       tx_on,
  input wire       rx_sleep_ctl,
  input wire       tx_empty_irq_en,
  input wire       tx_done_irq_en,
  input wire       rx_irq_en,
  input wire       idle_irq_en,
  input wire       status_rd,
  input wire       data_wr,
  input wire       data_rd,
  // status and pins
  input wire       tx_buf_empty_flag,
  input wire       tx_done_flag,
  input wire       rx_buf_full_flag,
  input wire       rx_overrun_flag,
  input wire       noise_flag,
  input wire       frame_error_flag,
  input wire       rx_idle_flag,
  input wire [7:0] rx_hold_reg,
  input wire       irq_req,
  input wire       rxd,
  input wire       txd,
  input wire       txd_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // cycles the raw line has stayed high, saturating
  reg [7:0] ones_reg;
  always @(posedge mclk or negedge rst_n)
    if (!rst_n)
      ones_reg <= 8'h00;
    else if (!rxd)
      ones_reg <= 8'h00;
    else if (ones_reg != 8'hFF)
      ones_reg <= ones_reg + 8'h01;
  tx_on_sets_a: assert property ($rose(tx_on) |=> tx_buf_empty_flag && tx_done_flag && txd_oe)
    else $error("turn-on did not set flags");
  empty_irq_a: assert property (tx_buf_empty_flag && tx_empty_irq_en |-> irq_req)
    else $error("empty irq missing");
  done_irq_a: assert property (tx_done_flag && tx_done_irq_en |-> irq_req)
    else $error("done irq missing");
  quiet_irq_a: assert property (irq_req |-> (tx_buf_empty_flag && tx_empty_irq_en) || (tx_done_flag && tx_done_irq_en)
    || ((rx_buf_full_flag || rx_overrun_flag) && rx_irq_en) || (rx_idle_flag && idle_irq_en))
    else $error("irq without enabled source");
  rx_clear_a: assert property ($fell(rx_buf_full_flag) || $fell(rx_overrun_flag) || $fell(noise_flag)
    || $fell(frame_error_flag) || $fell(rx_idle_flag) |-> $past(data_rd))
    else $error("rx flag cleared without data read");
  tx_clear_a: assert property (tx_buf_empty_flag && status_rd ##1 data_wr && !status_rd |=> !tx_buf_empty_flag)
    else $error("empty flag not cleared");
  overrun_keeps_a: assert property ($rose(rx_overrun_flag) |-> $stable(rx_hold_reg) && !$rose(rx_buf_full_flag))
    else $error("overrun disturbed held byte");
  idle_sleep_a: assert property ($rose(rx_idle_flag) |-> !$past(rx_sleep_ctl))
    else $error("idle set while asleep");
  idle_time_a: assert property ($rose(rx_idle_flag) |-> ones_reg >= 8'hA0)
    else $error("idle before a character time");
  oe_release_a: assert property ($fell(txd_oe) |-> $past(txd) ##[0:16] (tx_done_flag && tx_buf_empty_flag))
    else $error("pin released mid frame or flags not set");
  cover property ($rose(rx_overrun_flag));
  cover property ($rose(rx_idle_flag));
  cover property ($fell(txd_oe));
endmodule // asu_core_chk

bind asu_core asu_core_chk i_asu_core_chk (.mclk(mclk), .rst_n(rst_n), .tx_on(tx_on), .rx_sleep_ctl(rx_sleep_ctl),
  .tx_empty_irq_en(tx_empty_irq_en), .tx_done_irq_en(tx_done_irq_en), .rx_irq_en(rx_irq_en),
  .idle_irq_en(idle_irq_en), .status_rd(status_rd), .data_wr(data_wr), .data_rd(data_rd),
  .tx_buf_empty_flag(tx_buf_empty_flag), .tx_done_flag(tx_done_flag), .rx_buf_full_flag(rx_buf_full_flag),
  .rx_overrun_flag(rx_overrun_flag), .noise_flag(noise_flag), .frame_error_flag(frame_error_flag),
  .rx_idle_flag(rx_idle_flag), .rx_hold_reg(rx_hold_reg), .irq_req(irq_req), .rxd(rxd), .txd(txd), .txd_oe(txd_oe));

// *** testbench/asu_remote_node.sv ***
/*
  far serial node: sends frames on rxd and collects frames seen on txd.
  assumes bit_cyc mclk cycles per bit and a line pulled high when idle.
*/
`timescale 1ns/1ps
module asu_remote_node
(
  // clock
  input  wire        mclk,
  // line
  input  wire        txd,
  input  wire        txd_oe,
  output reg         rxd,
  // timing
  input  wire [15:0] bit_cyc
);
  reg [7:0] got_q [$];
  reg [7:0] sh;
  integer   i;
  wire      line;
  // a released pin floats up to the pull-up level
  assign line = txd_oe ? txd : 1'b1;
  initial rxd = 1'b1;
  // glitch flips the line for one cycle in the middle of data bit 0
  task send(input [7:0] b, input stop, input glitch);
    integer k;
    begin
      for (k = 0; k < 10; k = k + 1)
      begin
        @(posedge mclk);
        rxd <= (k == 0) ? 1'b0 : (k == 9) ? stop : b[k-1];
        if (glitch && k == 1)
        begin
          repeat (bit_cyc / 2) @(posedge mclk);
          rxd <= ~b[0];
          @(posedge mclk);
          rxd <= b[0];
          repeat (bit_cyc / 2 - 2) @(posedge mclk);
        end
        else
          repeat (bit_cyc - 1) @(posedge mclk);
      end
      @(posedge mclk);
      rxd <= 1'b1;
    end
  endtask
  always @(negedge line)
    if (txd_oe)
    begin
      repeat (bit_cyc + bit_cyc / 2) @(posedge mclk);
      for (i = 0; i < 8; i = i + 1)
      begin
        sh[i] = line;
        repeat (bit_cyc) @(posedge mclk);
      end
      got_q.push_back(sh);
    end
endmodule // asu_remote_node

// *** testbench/asu_core_bench.sv ***
/*
  bench for asu_core with a far serial node and a receive flag model.
  assumes a 200 MHz mclk and the prescale codes of the design.
*/
`timescale 1ns/1ps
module asu_core_bench;
  reg         mclk, rst_n, tx_on, rx_on, rx_sleep_ctl, status_rd, data_wr, data_rd;
  reg         tx_empty_irq_en, tx_done_irq_en, rx_irq_en, idle_irq_en;
  reg  [2:0]  baud_prescale_sel, baud_rate_sel;
  reg  [7:0]  tx_data;
  reg  [15:0] bit_cyc;
  reg  [31:0] seed;
  reg  [7:0]  exp_q [$];
  wire        tx_buf_empty_flag, tx_done_flag, rx_buf_full_flag, rx_overrun_flag;
  wire        noise_flag, frame_error_flag, rx_idle_flag, irq_req, rxd, txd, txd_oe;
  wire [7:0]  rx_hold_reg;
  integer     n_errors, samples_checked, t, k, e, m_hold, m_full, m_ovr, m_nf, m_fe, m_idle;
  asu_core i_asu_core (.mclk(mclk), .rst_n(rst_n), .baud_prescale_sel(baud_prescale_sel),
    .baud_rate_sel(baud_rate_sel), .tx_on(tx_on), .rx_on(rx_on), .rx_sleep_ctl(rx_sleep_ctl),
    .tx_empty_irq_en(tx_empty_irq_en), .tx_done_irq_en(tx_done_irq_en), .rx_irq_en(rx_irq_en),
    .idle_irq_en(idle_irq_en), .status_rd(status_rd), .data_wr(data_wr), .data_rd(data_rd), .tx_data(tx_data),
    .tx_buf_empty_flag(tx_buf_empty_flag), .tx_done_flag(tx_done_flag), .rx_buf_full_flag(rx_buf_full_flag),
    .rx_overrun_flag(rx_overrun_flag), .noise_flag(noise_flag), .frame_error_flag(frame_error_flag),
    .rx_idle_flag(rx_idle_flag), .rx_hold_reg(rx_hold_reg), .irq_req(irq_req), .rxd(rxd), .txd(txd),
    .txd_oe(txd_oe));
  asu_remote_node i_asu_remote_node (.mclk(mclk), .txd(txd), .txd_oe(txd_oe), .rxd(rxd), .bit_cyc(bit_cyc));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function integer div(input integer p);
    div = (p == 1) ? 3 : (p == 2) ? 4 : (p == 3) ? 13 : (p == 4) ? 39 : 1;
  endfunction
  function cond(input integer w);
    cond = (w == 0) ? tx_done_flag === 1'b1 : (w == 1) ? tx_buf_empty_flag === 1'b1 :
           (w == 2) ? txd === 1'b0 : txd_oe === 1'b0;
  endfunction
  task give_verdict;
    begin
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task await(input integer w);
    begin
      t = 0;
      do
      begin
        @(posedge mclk);
        t = t + 1;
      end while (t < 50000 && !cond(w));
      if (t == 50000)
      begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0t wait timed out", $time);
        give_verdict;
      end
    end
  endtask
  task strobe(input wr, input [7:0] d);
    begin
      @(posedge mclk);
      status_rd <= 1'b1;
      @(posedge mclk);
      status_rd <= 1'b0;
      data_wr   <= wr;
      data_rd   <= !wr;
      tx_data   <= d;
      @(posedge mclk);
      data_wr <= 1'b0;
      data_rd <= 1'b0;
    end
  endtask
  task rd_rx;
    begin
      strobe(1'b0, 8'h00);
      {m_full, m_ovr, m_nf, m_fe, m_idle} = 0;
    end
  endtask
  task rx(input stop, input glitch);
    begin
      seed = lfsr(seed);
      i_asu_remote_node.send(seed[7:0], stop, glitch);
      if (m_full)
        m_ovr = 1;
      else
      begin
        m_hold = seed[7:0];
        m_full = 1;
        m_nf   = glitch;
        m_fe   = !stop;
      end
      m_idle = 1;
      repeat (200) @(posedge mclk);
      chk(rx_hold_reg, m_hold[7:0]);
      chk(rx_buf_full_flag, m_full[0]);
      chk(rx_overrun_flag, m_ovr[0]);
      chk({noise_flag, frame_error_flag}, {m_nf[0], m_fe[0]});
      chk(rx_idle_flag, m_idle[0]);
    end
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial
  begin
    {rst_n, tx_on, rx_on, rx_sleep_ctl, status_rd, data_wr, data_rd} = 7'h00;
    {tx_empty_irq_en, tx_done_irq_en, rx_irq_en, idle_irq_en} = 4'h0;
    {baud_prescale_sel, baud_rate_sel, tx_data} = 14'h0000;
    {bit_cyc, seed} = {16'h0010, 32'h20B3};
    {n_errors, samples_checked, m_hold, m_full, m_ovr, m_nf, m_fe, m_idle} = 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk({txd, txd_oe, tx_buf_empty_flag, irq_req}, 16'h0008);
    tx_on           <= 1'b1;
    tx_empty_irq_en <= 1'b1;
    repeat (2) @(posedge mclk);
    chk({tx_buf_empty_flag, tx_done_flag, txd_oe, irq_req}, 16'h000F);
    tx_empty_irq_en <= 1'b0;
    tx_done_irq_en  <= 1'b1;
    for (k = 0; k < 3; k = k + 1)
    begin
      seed = lfsr(seed);
      exp_q.push_back(seed[7:0]);
      await(1);
      strobe(1'b1, seed[7:0]);
    end
    await(0);
    chk(irq_req, 1);
    chk(i_asu_remote_node.got_q.size(), 3);
    for (k = 0; k < 3; k = k + 1)
      chk(i_asu_remote_node.got_q[k], exp_q[k]);
    i_asu_remote_node.got_q.delete();
    strobe(1'b1, exp_q[1]);
    await(2);
    strobe(1'b1, 8'hA5);
    tx_on <= 1'b0;
    await(0);
    await(3);
    chk({tx_done_flag, tx_buf_empty_flag, txd}, 16'h0007);
    chk(i_asu_remote_node.got_q.size(), 1);
    chk(i_asu_remote_node.got_q[0], exp_q[1]);
    tx_on <= 1'b1;
    for (k = 0; k < 13; k = k + 1)
    begin
      e = (k < 6) ? 16 * div(k) : 16 << (k - 5);
      baud_prescale_sel <= (k < 6) ? 3'(k) : 3'h0;
      baud_rate_sel     <= (k < 6) ? 3'h0 : 3'(k - 5);
      bit_cyc           <= e[15:0];
      strobe(1'b1, 8'hFF);
      await(2);
      for (t = 0; txd === 1'b0 && t < 5000; t = t + 1)
        @(posedge mclk);
      chk(t[15:0], e[15:0]);
      await(0);
    end
    {baud_prescale_sel, baud_rate_sel, bit_cyc} <= {6'h00, 16'h0010};
    tx_on <= 1'b0;
    await(3);
    chk({txd, tx_done_flag, tx_buf_empty_flag}, 16'h0007);
    {rx_on, rx_irq_en, idle_irq_en, tx_done_irq_en} <= 4'hE;
    repeat (200) @(posedge mclk);
    rx(1'b1, 1'b0);
    chk(irq_req, 1);
    rx(1'b1, 1'b0);
    rd_rx;
    repeat (400) @(posedge mclk);
    chk({rx_buf_full_flag, rx_overrun_flag, rx_idle_flag}, 16'h0000);
    rx(1'b0, 1'b0);
    rd_rx;
    rx(1'b1, 1'b1);
    rd_rx;
    rx_sleep_ctl <= 1'b1;
    i_asu_remote_node.send(8'h3C, 1'b1, 1'b0);
    repeat (200) @(posedge mclk);
    chk(rx_idle_flag, 0);
    give_verdict;
  end
endmodule // asu_core_bench
